// File: prg_bitop.sv
// Store or bit set/clear/invert merge of one register byte.
// Assumes the old value is the current content of the addressed register.
module prg_bitop (
    input wire logic [7:0] old_val,
    input wire logic [7:0] wdata,
    input wire prg_pkg::prg_bitop_t op,
    input wire logic [2:0] bitn,
    output logic [7:0] new_val
);
    logic [7:0] sel;

    always_comb begin
        sel = 8'h01 << bitn;
        unique case (op)
            prg_pkg::BIT_SET: new_val = old_val | sel;
            prg_pkg::BIT_CLR: new_val = old_val & ~sel;
            prg_pkg::BIT_INV: new_val = old_val ^ sel;
            prg_pkg::BIT_NONE: new_val = wdata;
        endcase
    end

endmodule : prg_bitop

// File: prg_cpu_model.sv
// CPU core model: one-cycle stores and loads on the register port.
// Assumes tasks are entered just after a rising edge of clk.
module prg_cpu_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    output logic [1:0] bit_op,
    output logic [2:0] bit_num
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        bit_op = 2'h0;
        bit_num = 3'h0;
    end
    // Store or bit op; wr stays high until the next task, so stores called back to back have no gap
    task automatic store(input logic [7:0] a, input logic [7:0] d, input logic [1:0] op,
                         input logic [2:0] bn);
        addr <= a;
        wdata <= d;
        bit_op <= op;
        bit_num <= bn;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask : store
    // Load; data taken in the cycle after the strobe
    task automatic load(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        #1;
        d = rdata;
    endtask : load
    // Sole bus master, so no other write intervenes
    task automatic idle();
        addr <= ~addr;
        wdata <= ~wdata;
        bit_op <= ~bit_op;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask : idle
endmodule : prg_cpu_model

// File: prg_guard.sv
// Write guard for the five protected system registers, with error flag and interrupt.
// Assumes a CPU on the same clock issuing one-cycle write or read strobes.
//
// Local design decisions: the register addresses and the plain strobed port.
module prg_guard (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [1:0] BIT_OP,
    input wire logic [2:0] BIT_NUM,
    output logic [7:0] RDATA,
    output logic [7:0] POWER_SAVE_CTRL,
    output logic [7:0] CPU_CLOCK_CTRL,
    output logic [7:0] CLOCK_CTRL,
    output logic [7:0] WATCHDOG_MODE,
    output logic [7:0] WATCHDOG_RESET_STATUS,
    output logic PROTECT_ERROR,
    output logic INTR_HOLD,
    output logic IRQ
);

    prg_pkg::prg_req_t req;
    prg_pkg::prg_state_t state_ff;
    prg_pkg::prg_state_t nxt_state;
    prg_pkg::prg_prot_arr_t prot_ff;
    logic read_seen_ff;
    logic err_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] nxt_irq_stat;
    logic [1:0] irq_mask_ff;
    logic [1:0] nxt_irq_mask;
    logic irq_ff;
    logic [7:0] rdata_ff;
    logic [7:0] cur_val;
    logic [7:0] wval;
    logic armed;
    logic wr_cmd;
    logic wr_prot;
    logic wr_stat;
    logic wr_other;
    logic wr_wdt_mode;
    logic accept;
    logic viol;
    logic wbit_err;
    int widx;

    // Request bundle
    always_comb begin
        req.wr = WR;
        req.rd = RD;
        req.addr = ADDR;
        req.wdata = WDATA;
        req.op = prg_pkg::prg_bitop_t'(BIT_OP);
        req.bitn = BIT_NUM;
    end

    // Read view of the addressed register
    function automatic logic [7:0] read_mux(
        input logic [7:0] a,
        input prg_pkg::prg_prot_arr_t p,
        input logic e,
        input logic [1:0] s,
        input logic [1:0] m
    );
        int i;
        i = prg_pkg::prot_index(a);
        if (i != prg_pkg::PROT_N) begin
            read_mux = p[i];
        end else if (a == prg_pkg::OFS_STATUS) begin
            read_mux = {7'h00, e};
        end else if (a == prg_pkg::OFS_IRQ_STAT) begin
            read_mux = {6'h00, s};
        end else if (a == prg_pkg::OFS_IRQ_MASK) begin
            read_mux = {6'h00, m};
        end else begin
            read_mux = prg_pkg::RD_UNDEF;
        end
    endfunction : read_mux

    assign cur_val = read_mux(req.addr, prot_ff, err_ff, irq_stat_ff, irq_mask_ff);

    // Store or read-modify-write merge
    prg_bitop u_bitop (
        .old_val(cur_val),
        .wdata(req.wdata),
        .op(req.op),
        .bitn(req.bitn),
        .new_val(wval)
    );

    // Access decode
    always_comb begin
        armed = (state_ff == prg_pkg::ST_ARMED);
        widx = prg_pkg::prot_index(req.addr);
        wr_cmd = req.wr && (req.addr == prg_pkg::OFS_CMD);
        wr_prot = req.wr && prg_pkg::is_protected(req.addr);
        wr_stat = req.wr && (req.addr == prg_pkg::OFS_STATUS);
        wr_other = req.wr && !wr_cmd && !wr_prot && !wr_stat;
        wr_wdt_mode = req.wr && (req.addr == prg_pkg::OFS_WDT_MODE);
        wbit_err = wval[prg_pkg::ERR_BIT];
        // Watchdog mode loses its unlock once a read slipped in
        accept = wr_prot && armed && !(wr_wdt_mode && read_seen_ff);
        viol = (wr_prot && !accept) || (armed && (wr_cmd || wr_other));
    end

    // Unlock sequencer
    always_comb begin
        nxt_state = state_ff;
        if (req.wr) begin
            // Any write consumes the unlock; only an unarmed command write arms
            if (wr_cmd && !armed) begin
                nxt_state = prg_pkg::ST_ARMED;
            end else begin
                nxt_state = prg_pkg::ST_IDLE;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= prg_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Reads while armed are remembered, not punished
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            read_seen_ff <= 1'b0;
        end else if (req.wr) begin
            read_seen_ff <= 1'b0;
        end else if (req.rd && armed) begin
            read_seen_ff <= 1'b1;
        end
    end

    // Protected registers
    generate
        for (genvar g = 0; g < prg_pkg::PROT_N; g++) begin : g_prot
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    prot_ff[g] <= prg_pkg::prot_reset(g);
                end else if (accept && (widx == g)) begin
                    prot_ff[g] <= wval;
                end
            end
        end
    endgenerate

    // Error flag: violation sets, a direct write gives its value
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            err_ff <= 1'b0;
        end else if (viol) begin
            err_ff <= 1'b1;
        end else if (wr_stat) begin
            err_ff <= wbit_err;
        end
    end

    // Interrupt status, write one to clear, set wins
    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        if (req.wr && (req.addr == prg_pkg::OFS_IRQ_STAT)) begin
            nxt_irq_stat = irq_stat_ff & ~wval[1:0];
        end
        nxt_irq_stat[prg_pkg::EVT_VIOL_BIT] = nxt_irq_stat[prg_pkg::EVT_VIOL_BIT] | viol;
        nxt_irq_stat[prg_pkg::EVT_OK_BIT] = nxt_irq_stat[prg_pkg::EVT_OK_BIT] | accept;
    end

    always_comb begin
        nxt_irq_mask = irq_mask_ff;
        if (req.wr && (req.addr == prg_pkg::OFS_IRQ_MASK)) begin
            nxt_irq_mask = wval[1:0];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            irq_stat_ff <= prg_pkg::RST_IRQ_STAT;
            irq_mask_ff <= prg_pkg::RST_IRQ_MASK;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_ff <= 8'h00;
        end else if (req.rd) begin
            rdata_ff <= cur_val;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign RDATA = rdata_ff;
    assign POWER_SAVE_CTRL = prot_ff[0];
    assign CPU_CLOCK_CTRL = prot_ff[1];
    assign CLOCK_CTRL = prot_ff[2];
    assign WATCHDOG_MODE = prot_ff[3];
    assign WATCHDOG_RESET_STATUS = prot_ff[4];
    assign PROTECT_ERROR = err_ff;
    assign INTR_HOLD = armed;
    assign IRQ = irq_ff;

    // Checks
    AST_ARM_ON_CMD: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && (ADDR == prg_pkg::OFS_CMD) && !INTR_HOLD) |=> INTR_HOLD
    ) else $error("Command write did not arm the guard");

    AST_ARM_ONE_WRITE: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (INTR_HOLD && WR) |=> !INTR_HOLD
    ) else $error("Unlock survived a write");

    AST_BITOP_ACCEPT: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_CLK) && (BIT_OP == 2'h1))
            |=> CLOCK_CTRL == ($past(CLOCK_CTRL) | (8'h01 << $past(BIT_NUM)))
    ) else $error("Bit set on protected register not applied");

    AST_HOLD_AFTER_CMD: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && (ADDR == prg_pkg::OFS_CMD) && !INTR_HOLD) ##1 !WR |=> INTR_HOLD
    ) else $error("Interrupt hold dropped before the protected write");

    AST_UNARMED_ERR: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && prg_pkg::is_protected(ADDR) && !INTR_HOLD)
            |=> PROTECT_ERROR && $stable(POWER_SAVE_CTRL) && $stable(WATCHDOG_MODE)
    ) else $error("Unarmed protected write not flagged or not blocked");

    AST_ARMED_OTHER_ERR: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_IRQ_MASK)) |=> PROTECT_ERROR
    ) else $error("Armed write to free register not flagged");

    AST_READ_NEUTRAL: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (RD && !WR && INTR_HOLD) |=> INTR_HOLD && $stable(PROTECT_ERROR)
    ) else $error("Read disturbed the unlock or the error flag");

    AST_CMD_NO_DATA: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && (ADDR == prg_pkg::OFS_CMD))
            |=> $stable(CLOCK_CTRL) && $stable(WATCHDOG_RESET_STATUS) && $stable(CPU_CLOCK_CTRL)
    ) else $error("Command write altered a protected register");

    AST_ERR_DIRECT: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && (ADDR == prg_pkg::OFS_STATUS) && (BIT_OP == 2'h0))
            |=> PROTECT_ERROR == $past(WDATA[0])
    ) else $error("Error flag did not take the written value");

    AST_CMD_READ: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (RD && (ADDR == prg_pkg::OFS_CMD)) |=> RDATA == prg_pkg::RD_UNDEF
    ) else $error("Command register read not constant");

    AST_WDT_READ_BLOCK: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (INTR_HOLD && RD && !WR) ##1 (WR && (ADDR == prg_pkg::OFS_WDT_MODE))
            |=> PROTECT_ERROR && $stable(WATCHDOG_MODE)
    ) else $error("Watchdog mode written after an intervening read");

    AST_ACCEPT_STORE: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_POWER_SAVE) && (BIT_OP == 2'h0))
            |=> (POWER_SAVE_CTRL == $past(WDATA)) && !INTR_HOLD
    ) else $error("Armed store to power save control not applied");

    AST_WDT_ACCEPT: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_WDT_MODE) && (BIT_OP == 2'h0) && !read_seen_ff)
            |=> WATCHDOG_MODE == $past(WDATA)
    ) else $error("Armed store to watchdog mode not applied");

    AST_BITCLR_ACCEPT: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_WDT_RES) && (BIT_OP == 2'h2))
            |=> WATCHDOG_RESET_STATUS == ($past(WATCHDOG_RESET_STATUS) & ~(8'h01 << $past(BIT_NUM)))
    ) else $error("Bit clear on protected register not applied");

    AST_BITINV_ACCEPT: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_CPU_CLK) && (BIT_OP == 2'h3))
            |=> CPU_CLOCK_CTRL == ($past(CPU_CLOCK_CTRL) ^ (8'h01 << $past(BIT_NUM)))
    ) else $error("Bit invert on protected register not applied");

    AST_CMD_DOUBLE: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_CMD)) |=> PROTECT_ERROR && !INTR_HOLD
    ) else $error("Second command write not flagged");

    AST_ERR_ZERO_WINS: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && INTR_HOLD && (ADDR == prg_pkg::OFS_STATUS) && (BIT_OP == 2'h0) && !WDATA[0])
            |=> !PROTECT_ERROR
    ) else $error("Zero written after command did not clear the flag");

    AST_FREE_NO_ERR: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (WR && !INTR_HOLD && (ADDR == prg_pkg::OFS_IRQ_MASK)) |=> $stable(PROTECT_ERROR)
    ) else $error("Unarmed write to free register touched the flag");

    AST_IRQ_ON_VIOL: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (viol && irq_mask_ff[prg_pkg::EVT_VIOL_BIT] && !(WR && (ADDR == prg_pkg::OFS_IRQ_MASK)))
            |=> IRQ
    ) else $error("Unmasked violation did not raise the interrupt");

    AST_READ_KEEPS: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (RD && !WR) |=> $stable(POWER_SAVE_CTRL) && $stable(CLOCK_CTRL) && $stable(WATCHDOG_MODE)
    ) else $error("Read altered a protected register");

    AST_RDATA_PROT: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (RD && (ADDR == prg_pkg::OFS_WDT_RES)) |=> RDATA == $past(WATCHDOG_RESET_STATUS)
    ) else $error("Protected register read returned wrong data");

    AST_RDATA_IDLE: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !RD |=> RDATA == 8'h00
    ) else $error("Read data not zero outside the read cycle");

endmodule : prg_guard

// File: prg_pkg.sv
// Package for the protected register write guard.
// Assumes an 8-bit peripheral register port on one system clock.
package prg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PROT_N = 5;
    localparam int IRQ_W = 2;

    // Register offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h01;
    localparam logic [7:0] OFS_POWER_SAVE = 8'h02;
    localparam logic [7:0] OFS_CPU_CLK = 8'h03;
    localparam logic [7:0] OFS_CLK = 8'h04;
    localparam logic [7:0] OFS_WDT_MODE = 8'h05;
    localparam logic [7:0] OFS_WDT_RES = 8'h06;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h09;

    // Field positions
    localparam int ERR_BIT = 0;
    localparam int EVT_VIOL_BIT = 0;
    localparam int EVT_OK_BIT = 1;

    // Values after reset, and the read data of other offsets
    localparam logic [7:0] RST_POWER_SAVE = 8'h00;
    localparam logic [7:0] RST_CPU_CLK = 8'h00;
    localparam logic [7:0] RST_CLK = 8'h00;
    localparam logic [7:0] RST_WDT_MODE = 8'h00;
    localparam logic [7:0] RST_WDT_RES = 8'h00;
    localparam logic [1:0] RST_IRQ_STAT = 2'h0;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [7:0] RD_UNDEF = 8'h00;

    typedef enum logic [1:0] {
        BIT_NONE,
        BIT_SET,
        BIT_CLR,
        BIT_INV
    } prg_bitop_t;

    typedef enum logic {
        ST_IDLE,
        ST_ARMED
    } prg_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        prg_bitop_t op;
        logic [2:0] bitn;
    } prg_req_t;

    typedef logic [DATA_W-1:0] prg_prot_arr_t [PROT_N];

    // Index of a protected register, PROT_N when not protected
    function automatic int prot_index(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFS_POWER_SAVE: prot_index = 0;
            OFS_CPU_CLK: prot_index = 1;
            OFS_CLK: prot_index = 2;
            OFS_WDT_MODE: prot_index = 3;
            OFS_WDT_RES: prot_index = 4;
            default: prot_index = PROT_N;
        endcase
    endfunction : prot_index

    function automatic logic is_protected(input logic [ADDR_W-1:0] a);
        is_protected = (prot_index(a) != PROT_N);
    endfunction : is_protected

    function automatic logic [DATA_W-1:0] prot_reset(input int i);
        unique case (i)
            0: prot_reset = RST_POWER_SAVE;
            1: prot_reset = RST_CPU_CLK;
            2: prot_reset = RST_CLK;
            3: prot_reset = RST_WDT_MODE;
            default: prot_reset = RST_WDT_RES;
        endcase
    endfunction : prot_reset

endpackage : prg_pkg

// File: prg_tb.sv
// Self-checking bench of the write guard against an integer model.
// Assumes the CPU model drives the register port of the guard.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, err_q, hold_q, irq_q;
    logic [1:0] bit_op;
    logic [2:0] bit_num;
    logic [7:0] prot_q [5];
    logic [31:0] seed = 32'h0ba88158;
    int m_prot [5];
    int m_err, m_arm, m_rds, m_st, m_mk;
    int err_count = 0;
    int checked = 0;

    always #4 clk = ~clk;

    prg_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .bit_op(bit_op), .bit_num(bit_num));
    prg_guard dut (.CLOCK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .BIT_OP(bit_op), .BIT_NUM(bit_num), .RDATA(rdata),
        .POWER_SAVE_CTRL(prot_q[0]), .CPU_CLOCK_CTRL(prot_q[1]), .CLOCK_CTRL(prot_q[2]),
        .WATCHDOG_MODE(prot_q[3]), .WATCHDOG_RESET_STATUS(prot_q[4]),
        .PROTECT_ERROR(err_q), .INTR_HOLD(hold_q), .IRQ(irq_q));

    function automatic int rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return int'(seed[15:0]);
    endfunction : rnd
    function automatic int pidx(input int a);
        if (a >= prg_pkg::OFS_POWER_SAVE && a <= prg_pkg::OFS_WDT_RES)
            return a - prg_pkg::OFS_POWER_SAVE;
        return 5;
    endfunction : pidx
    function automatic int merge(input int old, input int d, input int op, input int bn);
        case (op)
            1: return old | (1 << bn);
            2: return old & ~(1 << bn) & 255;
            3: return (old ^ (1 << bn)) & 255;
            default: return d & 255;
        endcase
    endfunction : merge

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_bit
    task automatic chk();
        for (int i = 0; i < 5; i++)
            cmp_val(prot_q[i], 8'(m_prot[i]), "protected reg");
        cmp_bit(err_q, 1'(m_err), "error flag");
        cmp_bit(hold_q, 1'(m_arm), "intr hold");
    endtask : chk
    task automatic irqchk();
        cpu.idle();
        chk();
        cmp_bit(irq_q, 1'((m_st & m_mk) != 0), "irq");
    endtask : irqchk
    task automatic w(input int a, input int d, input int op = 0, input int bn = 0);
        int i;
        int viol;
        int ok;
        i = pidx(a);
        viol = 0;
        ok = 0;
        if (a == 0) begin
            viol = m_arm;
            m_arm = !m_arm;
            m_rds = 0;
        end else if (i < 5) begin
            if (m_arm && !(i == 3 && m_rds)) begin
                m_prot[i] = merge(m_prot[i], d, op, bn);
                ok = 1;
            end else
                viol = 1;
            m_arm = 0;
        end else begin
            if (a == 1)
                m_err = merge(m_err, d, op, bn) & 1;
            else
                viol = m_arm;
            if (a == 8)
                m_st = m_st & ~d;
            if (a == 9)
                m_mk = d & 3;
            m_arm = 0;
        end
        if (viol)
            m_err = 1;
        m_st = m_st | viol | (ok << 1);
        cpu.store(8'(a), 8'(d), 2'(op), 3'(bn));
        chk();
    endtask : w
    task automatic r(input int a);
        logic [7:0] got;
        int i;
        int e;
        i = pidx(a);
        if (m_arm)
            m_rds = 1;
        e = (i < 5) ? m_prot[i] : (a == 1) ? m_err : (a == 8) ? m_st : (a == 9) ? m_mk : 0;
        cpu.load(8'(a), got);
        cmp_val(got, 8'(e), "read data");
        chk();
    endtask : r
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        foreach (m_prot[i])
            m_prot[i] = 0;
        m_err = 0;
        m_arm = 0;
        m_rds = 0;
        m_st = 0;
        m_mk = 0;
        #1;
    endtask : do_reset
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        int a;
        do_reset();
        irqchk();
        for (int k = 0; k < 10; k++)
            r(k);
        r(127);
        $display("test reset and read sweep done");
        for (int i = 0; i < 5; i++) begin
            for (int op = 0; op < 4; op++) begin
                w(0, rnd());
                w(i + 2, rnd(), op, rnd() % 8);
            end
        end
        $display("test unlock and bit ops done");
        w(4, 8'h5a);
        w(1, 0);
        w(1, 1);
        w(0, 8'hff);
        w(1, 0);
        w(0, 8'h00);
        w(9, 3);
        irqchk();
        w(8, 3);
        irqchk();
        w(9, 0);
        w(4, 1);
        irqchk();
        $display("test error flag and irq done");
        w(0, 1);
        w(0, 2);
        w(4, 3);
        w(0, 4);
        r(2);
        r(6);
        w(4, 8'hc3);
        w(0, 5);
        r(2);
        w(5, 8'h77);
        $display("test ordering done");
        for (int k = 0; k < 80; k++) begin
            a = rnd() % 10;
            if (rnd() % 3 == 0)
                r(a);
            else
                w(a, rnd(), (a > 0 && a < 7) ? rnd() % 4 : 0, rnd() % 8);
        end
        irqchk();
        $display("test random traffic done");
        cpu.idle();
        do_reset();
        irqchk();
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : tb
